/* File: core/pcrm_pkg.sv */
// Shared constants, command codes, reset images and helpers of the command register map.
package pcrm_pkg;

  // ----------------------------------------------------------------
  // Command kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCRM_OP_SEND,
    PCRM_OP_WRITE,
    PCRM_OP_READ
  } pcrm_op_t;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_RUN = 8'h01;
  localparam logic [7:0] CMD_ENCFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_GUARD = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_FEATURE = 8'h19;
  localparam logic [7:0] CMD_VFORMAT = 8'h20;
  localparam logic [7:0] CMD_VSET = 8'h21;
  localparam logic [7:0] PAGE_ALL = 8'hff;

  // ----------------------------------------------------------------
  // Fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] FEATURE_VAL = 8'hb0;
  localparam logic [7:0] VFORMAT_VAL = 8'h16;
  localparam int NVM_CYCLES_DEF = 16;
  localparam int FLT_CML = 0;
  localparam int FLT_BUSY = 1;
  localparam int GUARD_ALL = 7;
  localparam int GUARD_RUN = 6;
  localparam int GUARD_SET = 5;

  // ----------------------------------------------------------------
  // Paged storage slots
  // ----------------------------------------------------------------
  localparam int NPG = 13;
  localparam int SL_RUN = 0;
  localparam int SL_VSET = 3;
  localparam int SL_VMAX = 4;
  localparam int SL_MHI = 5;
  localparam int SL_MLO = 6;
  localparam logic [7:0] PG_CODE [NPG] = '{8'h01, 8'h02, 8'h1b, 8'h21, 8'h24, 8'h25, 8'h26,
                                          8'h27, 8'h38, 8'h40, 8'h41, 8'h42, 8'h43};
  localparam logic [15:0] PG_RST [NPG] = '{16'h0040, 16'h001e, 16'h0000, 16'h1400, 16'ha000,
                                          16'h1500, 16'h1300, 16'haa00, 16'hbb9a, 16'h1600,
                                          16'h00b8, 16'h1580, 16'h1280};
  localparam logic [NPG-1:0] PG_BYTE = 13'h0407;

  // ----------------------------------------------------------------
  // Non-paged storage slots
  // ----------------------------------------------------------------
  localparam int NGL = 4;
  localparam int GL_GUARD = 0;
  localparam int GL_FREQ = 1;
  localparam logic [7:0] GL_CODE [NGL] = '{8'h10, 8'h33, 8'h35, 8'h36};
  localparam logic [15:0] GL_RST [NGL] = '{16'h0000, 16'hf3e8, 16'hcb40, 16'hcb00};
  localparam logic [NGL-1:0] GL_BYTE = 4'h1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Exponent in bits 15:11, mantissa in bits 10:0, both signed.
  function automatic logic signed [31:0] l11_value(input logic [15:0] v);
    logic signed [4:0] e;
    logic signed [31:0] m;
    logic [4:0] sh;
    e = v[15:11];
    m = 32'(signed'(v[10:0]));
    sh = (e < 0) ? 5'(-e) : 5'(e);
    if (e < 0) begin
      l11_value = m >>> sh;
    end else begin
      l11_value = m <<< sh;
    end
  endfunction

endpackage

/* File: core/pcrm_core.sv */
// Command-code register map behind the serial power-management slave.
`timescale 1ns/100ps
module pcrm_core
  import pcrm_pkg::*;
#(
  parameter int PAGES = 2,
  parameter int NVM_CYCLES = NVM_CYCLES_DEF,
  parameter int FLT = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire pcrm_op_t cmd_op_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_pp_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [FLT-1:0] fault_set_i,
  output logic cmd_ack_o,
  output logic cmd_busy_o,
  output logic [15:0] rsp_data_o,
  output logic [FLT-1:0] fault_flags_o,
  output logic nvm_busy_o,
  output logic [PAGES-1:0] output_on_o,
  output logic [PAGES*16-1:0] vout_target_o,
  output logic [15:0] switch_freq_khz_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int PW = (PAGES > 1) ? $clog2(PAGES) : 1;
  localparam int CW = $clog2(NVM_CYCLES + 1);
  localparam int NVM_BOUND = NVM_CYCLES + 2;

  if (PAGES < 1 || PAGES > 16) begin : g_bad_pages
    $error("PAGES must lie between 1 and 16.");
  end
  if (NVM_CYCLES < 1 || FLT < 2) begin : g_bad_nvm
    $error("NVM_CYCLES must be at least 1 and FLT at least 2.");
  end

  // ----------------------------------------------------------------
  // Local functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] pg_find(input logic [7:0] c);
    pg_find = 5'h00;
    for (int i = 0; i < NPG; i++) begin
      if (PG_CODE[i] == c) begin
        pg_find = {1'b1, 4'(i)};
      end
    end
  endfunction

  function automatic logic [2:0] gl_find(input logic [7:0] c);
    gl_find = 3'h0;
    for (int i = 0; i < NGL; i++) begin
      if (GL_CODE[i] == c) begin
        gl_find = {1'b1, 2'(i)};
      end
    end
  endfunction

  // Higher guard levels leave fewer codes writable.
  function automatic logic guard_allows(input logic [7:0] wp, input logic [7:0] c);
    logic base;
    logic run;
    base = (c == CMD_GUARD);
    run = base || c == CMD_PAGE || c == CMD_RUN;
    if (wp[GUARD_ALL]) begin
      guard_allows = base;
    end else if (wp[GUARD_RUN]) begin
      guard_allows = run;
    end else if (wp[GUARD_SET]) begin
      guard_allows = run || c == CMD_ENCFG || c == CMD_VSET;
    end else begin
      guard_allows = 1'b1;
    end
  endfunction

  // Margin selection in bits 5:4, then the ceiling clamp.
  function automatic logic [15:0] vout_pick(input logic [15:0] run, input logic [15:0] nom,
                                            input logic [15:0] hi, input logic [15:0] lo,
                                            input logic [15:0] cap);
    logic [15:0] sel;
    sel = (run[5:4] == 2'b10) ? hi : (run[5:4] == 2'b01) ? lo : nom;
    vout_pick = (sel > cap) ? cap : sel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PCRM_IDLE, PCRM_STORE, PCRM_RESTORE} pcrm_state_t;

  pcrm_state_t state_ff;
  logic [CW-1:0] nvm_cnt_ff;
  logic [7:0] page_ff;
  logic [15:0] pg_ff [PAGES][NPG];
  logic [15:0] gl_ff [NGL];
  logic [15:0] nv_pg_ff [PAGES][NPG];
  logic [15:0] nv_gl_ff [NGL];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [4:0] pg_hit;
  logic [2:0] gl_hit;
  logic [7:0] eff_page;
  logic all_pages;
  logic page_ok;
  logic [PW-1:0] rd_page;
  logic accept;
  logic legal;
  logic nvm_done;
  logic [15:0] rdata;

  always_comb begin
    pg_hit = pg_find(cmd_code_i);
    gl_hit = gl_find(cmd_code_i);
    eff_page = cmd_pp_i ? cmd_page_i : page_ff;
    all_pages = (eff_page == PAGE_ALL);
    page_ok = all_pages || (eff_page < 8'(PAGES));
    rd_page = all_pages ? '0 : eff_page[PW-1:0];
    accept = cmd_valid_i && (state_ff == PCRM_IDLE);
    nvm_done = (state_ff != PCRM_IDLE) && (nvm_cnt_ff == CW'(NVM_CYCLES - 1));
  end

  always_comb begin
    legal = 1'b0;
    rdata = 16'h0000;
    unique case (cmd_op_i)
      PCRM_OP_SEND: begin
        legal = !cmd_pp_i && (cmd_code_i == CMD_CLEAR || cmd_code_i == CMD_STORE ||
                              cmd_code_i == CMD_RESTORE);
      end
      PCRM_OP_WRITE: begin
        legal = ((pg_hit[4] && page_ok) || gl_hit[2] || cmd_code_i == CMD_PAGE) &&
                guard_allows(gl_ff[GL_GUARD][7:0], cmd_code_i);
      end
      PCRM_OP_READ: begin
        if (pg_hit[4] && page_ok) begin
          legal = 1'b1;
          rdata = pg_ff[rd_page][pg_hit[3:0]];
        end else if (gl_hit[2]) begin
          legal = 1'b1;
          rdata = gl_ff[gl_hit[1:0]];
        end else if (cmd_code_i == CMD_PAGE) begin
          legal = 1'b1;
          rdata = {8'h00, page_ff};
        end else if (cmd_code_i == CMD_FEATURE) begin
          legal = 1'b1;
          rdata = {8'h00, FEATURE_VAL};
        end else if (cmd_code_i == CMD_VFORMAT && page_ok) begin
          legal = 1'b1;
          rdata = {8'h00, VFORMAT_VAL};
        end
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Answer to the command port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ack_o <= 1'b0;
      cmd_busy_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end else begin
      cmd_ack_o <= accept;
      cmd_busy_o <= cmd_valid_i && !accept;
      if (accept && cmd_op_i == PCRM_OP_READ && legal) begin
        rsp_data_o <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  // A new event in the clearing cycle survives, so no fault is lost.
  logic [FLT-1:0] nxt_events;
  always_comb begin
    nxt_events = fault_set_i;
    nxt_events[FLT_CML] = fault_set_i[FLT_CML] || (accept && !legal);
    nxt_events[FLT_BUSY] = fault_set_i[FLT_BUSY] || (cmd_valid_i && !accept);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_flags_o <= '0;
    end else if (accept && legal && cmd_op_i == PCRM_OP_SEND && cmd_code_i == CMD_CLEAR) begin
      fault_flags_o <= nxt_events;
    end else begin
      fault_flags_o <= fault_flags_o | nxt_events;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile store and restore sequencer
  // ----------------------------------------------------------------
  // The copy takes NVM_CYCLES; commands in that window are turned away busy.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= PCRM_IDLE;
      nvm_cnt_ff <= '0;
      nvm_busy_o <= 1'b0;
    end else begin
      unique case (state_ff)
        PCRM_IDLE: begin
          nvm_cnt_ff <= '0;
          if (accept && legal && cmd_op_i == PCRM_OP_SEND && cmd_code_i != CMD_CLEAR) begin
            state_ff <= (cmd_code_i == CMD_STORE) ? PCRM_STORE : PCRM_RESTORE;
            nvm_busy_o <= 1'b1;
          end
        end
        PCRM_STORE, PCRM_RESTORE: begin
          nvm_cnt_ff <= nvm_cnt_ff + CW'(1);
          if (nvm_done) begin
            state_ff <= PCRM_IDLE;
            nvm_busy_o <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int s = 0; s < NPG; s++) begin
          nv_pg_ff[p][s] <= PG_RST[s];
        end
      end
      for (int g = 0; g < NGL; g++) begin
        nv_gl_ff[g] <= GL_RST[g];
      end
    end else if (nvm_done && state_ff == PCRM_STORE) begin
      nv_pg_ff <= pg_ff;
      nv_gl_ff <= gl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Live register file
  // ----------------------------------------------------------------
  logic wr_go;
  logic [15:0] wr_val;
  always_comb begin
    wr_go = accept && legal && cmd_op_i == PCRM_OP_WRITE;
    wr_val = cmd_wdata_i;
    if ((pg_hit[4] && PG_BYTE[pg_hit[3:0]]) || (gl_hit[2] && GL_BYTE[gl_hit[1:0]])) begin
      wr_val = {8'h00, cmd_wdata_i[7:0]};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_ff <= PAGE_RST;
    end else if (wr_go && cmd_code_i == CMD_PAGE && !cmd_pp_i) begin
      page_ff <= cmd_wdata_i[7:0];
    end
  end

  // Paged settings: run control, enable source, set points, margins, slew rate,
  // sense gain and overvoltage level and action live here.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int s = 0; s < NPG; s++) begin
          pg_ff[p][s] <= PG_RST[s];
        end
      end
    end else if (nvm_done && state_ff == PCRM_RESTORE) begin
      pg_ff <= nv_pg_ff;
    end else if (wr_go && pg_hit[4]) begin
      for (int p = 0; p < PAGES; p++) begin
        if (all_pages || eff_page == 8'(p)) begin
          pg_ff[p][pg_hit[3:0]] <= wr_val;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int g = 0; g < NGL; g++) begin
        gl_ff[g] <= GL_RST[g];
      end
    end else if (nvm_done && state_ff == PCRM_RESTORE) begin
      gl_ff <= nv_gl_ff;
    end else if (wr_go && gl_hit[2]) begin
      gl_ff[gl_hit[1:0]] <= wr_val;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Margins outside the nominal bracket are the host's problem; only the
  // ceiling is enforced here, since it protects the load.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      output_on_o <= '0;
      vout_target_o <= '0;
      switch_freq_khz_o <= 16'h0000;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        output_on_o[p] <= pg_ff[p][SL_RUN][7];
        vout_target_o[p*16 +: 16] <= vout_pick(pg_ff[p][SL_RUN], pg_ff[p][SL_VSET],
                                               pg_ff[p][SL_MHI], pg_ff[p][SL_MLO],
                                               pg_ff[p][SL_VMAX]);
      end
      switch_freq_khz_o <= 16'(l11_value(gl_ff[GL_FREQ]));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_store_cmd;
    accept && cmd_op_i == PCRM_OP_SEND && cmd_code_i == CMD_STORE && !cmd_pp_i;
  endsequence

  sequence s_store_end;
    !nvm_busy_o && nv_pg_ff[0][SL_VSET] == pg_ff[0][SL_VSET];
  endsequence

  property p_unsupported;
    accept && cmd_op_i == PCRM_OP_READ && cmd_code_i == 8'h04
      |=> cmd_ack_o && fault_flags_o[FLT_CML];
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("Unsupported code no fault.");

  property p_format;
    accept && cmd_op_i == PCRM_OP_READ && cmd_code_i == CMD_VFORMAT && page_ok
      |=> rsp_data_o == 16'h0016;
  endproperty
  a_format: assert property (p_format) else $error("Format byte not 0x16.");

  property p_busy;
    cmd_valid_i && nvm_busy_o |=> cmd_busy_o && !cmd_ack_o && fault_flags_o[FLT_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("Command during busy not answered busy.");

  property p_pp_page;
    accept && cmd_pp_i |=> $stable(page_ff);
  endproperty
  a_pp_page: assert property (p_pp_page) else $error("Page-plus changed the page.");

  property p_clear;
    accept && cmd_op_i == PCRM_OP_SEND && cmd_code_i == CMD_CLEAR && !cmd_pp_i &&
      fault_set_i == '0 |=> fault_flags_o == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Faults not cleared.");

  property p_store;
    s_store_cmd |=> nvm_busy_o ##[1:NVM_BOUND] s_store_end;
  endproperty
  a_store: assert property (p_store) else $error("Store did not complete.");

  property p_feature;
    accept && cmd_op_i == PCRM_OP_READ && cmd_code_i == CMD_FEATURE |=> rsp_data_o == 16'h00b0;
  endproperty
  a_feature: assert property (p_feature) else $error("Feature byte not 0xb0.");

  property p_ceiling;
    ##1 vout_target_o[15:0] <= $past(pg_ff[0][SL_VMAX]);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("Target above ceiling.");

  property p_guard;
    accept && cmd_op_i == PCRM_OP_WRITE && gl_ff[GL_GUARD][GUARD_ALL] &&
      cmd_code_i != CMD_GUARD |=> fault_flags_o[FLT_CML] && $stable(page_ff);
  endproperty
  a_guard: assert property (p_guard) else $error("Guarded write accepted.");

  property p_page_reset;
    $fell(rst_i) |-> page_ff == 8'h00 && pg_ff[0][SL_RUN] == 16'h0040;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("Bad reset image.");

endmodule

/* File: testbench/pcrm_host.sv */
// Command master model standing in for the bus host of the register map.
`timescale 1ns/100ps
module pcrm_host
  import pcrm_pkg::*;
(
  input wire logic clk_i,
  output logic valid_o,
  output pcrm_op_t op_o,
  output logic [7:0] code_o,
  output logic pp_o,
  output logic [7:0] page_o,
  output logic [15:0] wdata_o
);
  initial begin
    valid_o = 1'b0;
    op_o = PCRM_OP_READ;
    code_o = 8'h5a;
    pp_o = 1'b0;
    page_o = 8'ha5;
    wdata_o = 16'h5a5a;
  end

  // The request stands for one taking edge; afterwards the data lines show the
  // inverse of the last value so a stale command never looks like a fresh one.
  task automatic xfer(input pcrm_op_t op, input logic [7:0] code, input logic pp,
                      input logic [7:0] pg, input logic [15:0] wd);
    if (op == PCRM_OP_WRITE && code >= 8'hd0) begin
      return;
    end
    @(posedge clk_i);
    valid_o <= 1'b1;
    op_o <= op;
    code_o <= code;
    pp_o <= pp;
    page_o <= pg;
    wdata_o <= wd;
    @(posedge clk_i);
    valid_o <= 1'b0;
    code_o <= ~code;
    page_o <= ~pg;
    wdata_o <= ~wd;
    #1;
  endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the command register map.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench
  import pcrm_pkg::*;
;
  typedef struct {pcrm_op_t op; logic [7:0] code; logic [15:0] rsp; logic flt;} pcrm_row_t;
  localparam pcrm_op_t RD = PCRM_OP_READ;
  localparam pcrm_op_t WR = PCRM_OP_WRITE;
  localparam pcrm_op_t SD = PCRM_OP_SEND;
  logic core_clk_i;
  logic rst_i;
  logic cmd_valid_i;
  pcrm_op_t cmd_op_i;
  logic [7:0] cmd_code_i;
  logic cmd_pp_i;
  logic [7:0] cmd_page_i;
  logic [15:0] cmd_wdata_i;
  logic [7:0] fault_set_i;
  logic cmd_ack_o;
  logic cmd_busy_o;
  logic [15:0] rsp_data_o;
  logic [7:0] fault_flags_o;
  logic nvm_busy_o;
  logic [1:0] output_on_o;
  logic [31:0] vout_target_o;
  logic [15:0] switch_freq_khz_o;
  int error_cnt = 0;
  int check_count = 0;
  pcrm_row_t rows [25] = '{
    '{RD, 8'h00, 16'h0000, 1'b0}, '{RD, 8'h01, 16'h0040, 1'b0},
    '{RD, 8'h02, 16'h001e, 1'b0}, '{RD, 8'h10, 16'h0000, 1'b0},
    '{RD, 8'h19, 16'h00b0, 1'b0}, '{RD, 8'h1b, 16'h0000, 1'b0},
    '{RD, 8'h20, 16'h0016, 1'b0}, '{RD, 8'h21, 16'h1400, 1'b0},
    '{RD, 8'h24, 16'ha000, 1'b0}, '{RD, 8'h25, 16'h1500, 1'b0},
    '{RD, 8'h26, 16'h1300, 1'b0}, '{RD, 8'h27, 16'haa00, 1'b0},
    '{RD, 8'h33, 16'hf3e8, 1'b0}, '{RD, 8'h35, 16'hcb40, 1'b0},
    '{RD, 8'h36, 16'hcb00, 1'b0}, '{RD, 8'h38, 16'hbb9a, 1'b0},
    '{RD, 8'h40, 16'h1600, 1'b0}, '{RD, 8'h41, 16'h00b8, 1'b0},
    '{RD, 8'h42, 16'h1580, 1'b0}, '{RD, 8'h43, 16'h1280, 1'b0},
    '{WR, 8'h19, 16'h1280, 1'b1}, '{WR, 8'h20, 16'h1280, 1'b1},
    '{RD, 8'h04, 16'h1280, 1'b1}, '{RD, 8'hd5, 16'h1280, 1'b1},
    '{RD, 8'h03, 16'h1280, 1'b1}};

  pcrm_host pcrm_host_inst (
    .clk_i(core_clk_i),
    .valid_o(cmd_valid_i),
    .op_o(cmd_op_i),
    .code_o(cmd_code_i),
    .pp_o(cmd_pp_i),
    .page_o(cmd_page_i),
    .wdata_o(cmd_wdata_i)
  );

  pcrm_core #(.NVM_CYCLES(4)) pcrm_core_inst (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i),
    .cmd_code_i(cmd_code_i),
    .cmd_pp_i(cmd_pp_i),
    .cmd_page_i(cmd_page_i),
    .cmd_wdata_i(cmd_wdata_i),
    .fault_set_i(fault_set_i),
    .cmd_ack_o(cmd_ack_o),
    .cmd_busy_o(cmd_busy_o),
    .rsp_data_o(rsp_data_o),
    .fault_flags_o(fault_flags_o),
    .nvm_busy_o(nvm_busy_o),
    .output_on_o(output_on_o),
    .vout_target_o(vout_target_o),
    .switch_freq_khz_o(switch_freq_khz_o)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic run(input pcrm_op_t op, input logic [7:0] code, input logic [15:0] wd,
                     input logic pp = 1'b0, input logic [7:0] pg = 8'h00);
    pcrm_host_inst.xfer(op, code, pp, pg, wd);
  endtask

  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic clear();
    run(SD, CMD_CLEAR, 16'h0000);
    `CHK("flags", 8'h00, fault_flags_o)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A store or restore has a bounded length; a stuck busy ends the run.
  task automatic wait_nvm();
    for (int i = 0; i < 20 && nvm_busy_o !== 1'b0; i++) begin
      settle();
    end
    if (nvm_busy_o !== 1'b0) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    fault_set_i = 8'h00;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    settle();
    `CHK("target", 32'h14001400, vout_target_o)
    `CHK("freq", 16'h00fa, switch_freq_khz_o)
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].code, 16'h0000);
      `CHK("ack", 1'b1, cmd_ack_o)
      `CHK("rsp", rows[i].rsp, rsp_data_o)
      `CHK("cml", rows[i].flt, fault_flags_o[FLT_CML])
      clear();
    end
    @(posedge core_clk_i);
    fault_set_i <= 8'h80;
    @(posedge core_clk_i);
    fault_set_i <= 8'h00;
    #1;
    `CHK("ext", 8'h80, fault_flags_o)
    clear();
    // Set points stay between the two margins throughout.
    run(WR, CMD_VSET, 16'h1480);
    run(SD, CMD_STORE, 16'h0000);
    `CHK("nvm", 1'b1, nvm_busy_o)
    run(RD, CMD_VSET, 16'h0000);
    `CHK("busy", 1'b1, cmd_busy_o)
    `CHK("noack", 1'b0, cmd_ack_o)
    `CHK("bflag", 1'b1, fault_flags_o[FLT_BUSY])
    wait_nvm();
    clear();
    run(WR, CMD_VSET, 16'h1380);
    run(SD, CMD_RESTORE, 16'h0000);
    wait_nvm();
    run(RD, CMD_VSET, 16'h0000);
    `CHK("restore", 16'h1480, rsp_data_o)
    run(WR, CMD_VSET, 16'h1440, 1'b1, 8'h01);
    run(RD, CMD_PAGE, 16'h0000);
    `CHK("page", 16'h0000, rsp_data_o)
    run(RD, CMD_VSET, 16'h0000, 1'b1, 8'h01);
    `CHK("pp", 16'h1440, rsp_data_o)
    settle();
    `CHK("tgt1", 16'h1440, vout_target_o[31:16])
    run(WR, CMD_RUN, 16'h00a0);
    run(WR, 8'h24, 16'h14c0);
    settle();
    `CHK("on", 1'b1, output_on_o[0])
    `CHK("clamp", 16'h14c0, vout_target_o[15:0])
    run(WR, CMD_GUARD, 16'h0080);
    run(WR, CMD_VSET, 16'h1400);
    `CHK("guard", 1'b1, fault_flags_o[FLT_CML])
    run(WR, CMD_GUARD, 16'h0000);
    run(RD, CMD_VSET, 16'h0000);
    `CHK("kept", 16'h1480, rsp_data_o)
    clear();
    run(WR, 8'h33, 16'h0064);
    settle();
    `CHK("freq2", 16'h0064, switch_freq_khz_o)
    // An all-pages write reaches both pages; page 1's output shows it, page 0 runs on its lower margin.
    run(WR, CMD_VSET, 16'h1420, 1'b1, PAGE_ALL);
    run(WR, CMD_RUN, 16'h0090);
    settle();
    `CHK("low", 16'h1300, vout_target_o[15:0])
    `CHK("all", 16'h1420, vout_target_o[31:16])
    // A reset in mid-run must bring back every default and drop sticky faults.
    run(WR, CMD_PAGE, 16'h0001);
    run(RD, 8'h04, 16'h0000);
    `CHK("pre", 1'b1, fault_flags_o[FLT_CML])
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    settle();
    `CHK("rtgt", 32'h14001400, vout_target_o)
    `CHK("rfreq", 16'h00fa, switch_freq_khz_o)
    `CHK("ron", 1'b0, output_on_o[0])
    `CHK("rflag", 8'h00, fault_flags_o)
    run(RD, CMD_VSET, 16'h0000);
    `CHK("rvset", 16'h1400, rsp_data_o)
    run(RD, CMD_PAGE, 16'h0000);
    `CHK("rpage", 16'h0000, rsp_data_o)
    tally_and_finish();
  end
endmodule
